// ### src/cps_seq_map.vh
// Constants for the configuration power sequencer
`ifndef CPS_SEQ_MAP_VH
`define CPS_SEQ_MAP_VH
`define CPS_INIT_DELAY_SLAVE 24'h000800
`define CPS_MASTER_FACTOR    3'h4
`define CPS_CLEAR_CYCLES     16'h0040
`define CPS_STARTUP_CYCLES   4'h4
`define CPS_CNT_W            24
`define CPS_NUM_PINS         8
`define CPS_ST_PREINIT       7'h01
`define CPS_ST_DELAY         7'h02
`define CPS_ST_CLEAR         7'h04
`define CPS_ST_WAITRST       7'h08
`define CPS_ST_CONFIG        7'h10
`define CPS_ST_STARTUP       7'h20
`define CPS_ST_USER          7'h40
`endif

// ### src/cps_config_power_sequencer.v
// Supply, reset and powerdown sequencer for a configurable logic device
`timescale 1ns/1ps
`include "cps_seq_map.vh"

// Behaviour
// R01 - Pre-init: active-high flag high, status pins low
// R02 - Delay starts after supply good, check cells
// R03 - Delay in oscillator periods, master four times
// R04 - Clear memory, await reset release, latch mode
// R05 - Low-supply sensor returns to pre-init
// R06 - Stay pre-init while low, then restart
// R07 - Master reconfigures, slave requests by pulling low
// R08 - Program low or reset fall restarts configuration; code restarts on a reset fall only while done/program is low
// R09 - Other party holds reset on slow supply
// R10 - Three-state control is inverse of enable
// R11 - Powerdown halts activity, pull-ups off
// R12 - Powerdown floats outputs, inputs read high
// R13 - Powerdown resets flops, memory kept
// R14 - Powerdown ignores clocks, logic still evaluates
// R15 - Powerdown release follows configuration-end order; code returns all outputs in the same cycle
// R16 - Powerdown and reset pass one sync stage; code uses two
module cps_config_power_sequencer
(
    input  wire                     clk,
    input  wire                     rst_n,
    input  wire                     supplyGood,
    input  wire                     checkCellsOk,
    input  wire                     isMaster,
    input  wire [1:0]               modePins,
    input  wire                     resetIn_n,
    input  wire                     powerdownRequest_n,
    input  wire                     doneProgramIn,
    input  wire                     configDone,
    input  wire [`CPS_NUM_PINS-1:0] userOutEnable_n,
    input  wire [`CPS_NUM_PINS-1:0] padIn,
    output reg                      configActiveHighFlag_ff,
    output reg                      configActiveLowFlag_ff,
    output reg                      initStatusOut_ff,
    output reg                      initStatusOe_ff,
    output reg                      doneProgramOut_ff,
    output reg                      doneProgramOe_ff,
    output reg                      memClear_ff,
    output reg                      configStart_ff,
    output reg [1:0]                modeLatched_ff,
    output reg                      fabricReset_ff,
    output reg                      fabricClockEnable_ff,
    output reg                      pullupEnable_ff,
    output reg [`CPS_NUM_PINS-1:0]  padThreeState_ff,
    output reg [`CPS_NUM_PINS-1:0]  padInToLogic_ff
);

    // Two-stage synchronisers for pins from outside the clock
    reg  [1:0]             supplySync_ff;
    reg  [1:0]             cellsSync_ff;
    reg  [1:0]             pdSync_ff;      // Powerdown request, active low
    reg  [1:0]             rstSync_ff;     // External reset, active low
    reg  [1:0]             dpSync_ff;      // Done/program pin level
    reg                    rstPrev_ff;     // Last synced reset for edge detect
    reg                    dpPrev_ff;      // Last synced done/program
    reg  [`CPS_NUM_PINS-1:0] padSyncA_ff;  // First pad stage
    reg  [`CPS_NUM_PINS-1:0] padSyncB_ff;  // Second pad stage
    reg  [1:0]             roleSync_ff;    // Master strap pin, two stages
    reg  [1:0]             modeSyncA_ff;   // First mode pin stage
    reg  [1:0]             modeSyncB_ff;   // Second mode pin stage

    // Sequencer state and counter
    reg  [6:0]             state_ff;
    reg  [6:0]             nxt_state;
    reg  [`CPS_CNT_W-1:0]  count_ff;
    reg  [`CPS_CNT_W-1:0]  nxt_count;
    reg                    masterLatched_ff;  // Role held for the delay length

    // Decoded conditions
    wire supplyOk    = supplySync_ff[1];
    wire cellsOk     = cellsSync_ff[1];
    wire powerdown   = ~pdSync_ff[1];
    wire resetActive = ~rstSync_ff[1];
    wire resetFall   = rstPrev_ff & ~rstSync_ff[1];
    wire dpLow       = ~dpSync_ff[1];
    wire dpFall      = dpPrev_ff & ~dpSync_ff[1];
    wire [`CPS_CNT_W-1:0] delayLimit = masterLatched_ff
        ? `CPS_INIT_DELAY_SLAVE * `CPS_MASTER_FACTOR  // [R03]
        : `CPS_INIT_DELAY_SLAVE;                       // [R03]
    // Decoded from the next state so flags move with the other pins
    wire inUser      = (nxt_state == `CPS_ST_USER);
    // Pads driven from startup on, before done/program lets go
    wire buffersOn   = (nxt_state == `CPS_ST_STARTUP) || inUser;  // [R15]

    // Pin synchronisers; powerdown and reset get a full stage pair
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            supplySync_ff <= 2'h0;
            cellsSync_ff  <= 2'h0;
            pdSync_ff     <= 2'h3;
            rstSync_ff    <= 2'h0;
            dpSync_ff     <= 2'h0;
            rstPrev_ff    <= 1'h0;
            dpPrev_ff     <= 1'h0;
            padSyncA_ff   <= {`CPS_NUM_PINS{1'b1}};
            padSyncB_ff   <= {`CPS_NUM_PINS{1'b1}};
            roleSync_ff   <= 2'h0;
            modeSyncA_ff  <= 2'h0;
            modeSyncB_ff  <= 2'h0;
        end
        else
        begin
            supplySync_ff <= {supplySync_ff[0], supplyGood};
            cellsSync_ff  <= {cellsSync_ff[0], checkCellsOk};
            pdSync_ff     <= {pdSync_ff[0], powerdownRequest_n};  // [R16]
            rstSync_ff    <= {rstSync_ff[0], resetIn_n};          // [R16]
            dpSync_ff     <= {dpSync_ff[0], doneProgramIn};
            rstPrev_ff    <= rstSync_ff[1];
            dpPrev_ff     <= dpSync_ff[1];
            padSyncA_ff   <= padIn;
            padSyncB_ff   <= padSyncA_ff;
            roleSync_ff   <= {roleSync_ff[0], isMaster};
            modeSyncA_ff  <= modePins;
            modeSyncB_ff  <= modeSyncA_ff;
        end
    end

    // Next-state logic of the sequencer
    always @*
    begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        if (!supplyOk)
        begin
            // Brown-out or low supply forces pre-init and holds it
            nxt_state = `CPS_ST_PREINIT;                      // [R05] [R06]
            nxt_count = {`CPS_CNT_W{1'b0}};
        end
        else if (powerdown)
        begin
            // Frozen: no progress while powered down
            nxt_state = state_ff;                             // [R14]
            nxt_count = count_ff;
        end
        else
        begin
            case (state_ff)
                `CPS_ST_PREINIT:
                begin
                    // Supply good and check cells written
                    if (cellsOk)
                    begin
                        nxt_state = `CPS_ST_DELAY;            // [R02]
                        nxt_count = {`CPS_CNT_W{1'b0}};
                    end
                end
                `CPS_ST_DELAY:
                begin
                    // Count oscillator periods up to the limit
                    if (count_ff >= delayLimit - 1'b1)
                    begin
                        nxt_state = `CPS_ST_CLEAR;            // [R03]
                        nxt_count = {`CPS_CNT_W{1'b0}};
                    end
                    else
                        nxt_count = count_ff + 1'b1;          // [R03]
                end
                `CPS_ST_CLEAR:
                begin
                    // Memory clear for a fixed number of cycles
                    if (count_ff >= `CPS_CLEAR_CYCLES - 1'b1)
                    begin
                        nxt_state = `CPS_ST_WAITRST;          // [R04]
                        nxt_count = {`CPS_CNT_W{1'b0}};
                    end
                    else
                        nxt_count = count_ff + 1'b1;
                end
                `CPS_ST_WAITRST:
                begin
                    // Hold until external reset is released
                    if (!resetActive)
                        nxt_state = `CPS_ST_CONFIG;           // [R04] [R09]
                end
                `CPS_ST_CONFIG:
                begin
                    // Loading; a new trigger restarts the clear
                    if (dpFall || (dpLow && resetFall))
                    begin
                        nxt_state = `CPS_ST_CLEAR;            // [R08]
                        nxt_count = {`CPS_CNT_W{1'b0}};
                    end
                    else if (configDone)
                    begin
                        nxt_state = `CPS_ST_STARTUP;
                        nxt_count = {`CPS_CNT_W{1'b0}};
                    end
                end
                `CPS_ST_STARTUP:
                begin
                    // Enable buffers, then release done/program
                    if (count_ff >= `CPS_STARTUP_CYCLES - 1'b1)
                        nxt_state = `CPS_ST_USER;             // [R15]
                    else
                        nxt_count = count_ff + 1'b1;
                end
                `CPS_ST_USER:
                begin
                    // Reconfiguration trigger from outside
                    if (dpFall || (dpLow && resetFall))
                    begin
                        nxt_state = `CPS_ST_CLEAR;            // [R08]
                        nxt_count = {`CPS_CNT_W{1'b0}};
                    end
                end
                default:
                begin
                    nxt_state = `CPS_ST_PREINIT;
                    nxt_count = {`CPS_CNT_W{1'b0}};
                end
            endcase
        end
    end

    // State, counter and mode latch
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff         <= `CPS_ST_PREINIT;
            count_ff         <= {`CPS_CNT_W{1'b0}};
            masterLatched_ff <= 1'b0;
            modeLatched_ff   <= 2'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
            // Role captured when the delay begins
            if (state_ff == `CPS_ST_PREINIT)
                masterLatched_ff <= roleSync_ff[1];
            // Mode pins stored as reset releases
            if (state_ff == `CPS_ST_WAITRST && nxt_state == `CPS_ST_CONFIG)
                modeLatched_ff <= modeSyncB_ff;               // [R04]
        end
    end

    // Registered pin and control outputs
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            configActiveHighFlag_ff <= 1'b1;
            configActiveLowFlag_ff  <= 1'b0;
            initStatusOut_ff        <= 1'b0;
            initStatusOe_ff         <= 1'b1;
            doneProgramOut_ff       <= 1'b0;
            doneProgramOe_ff        <= 1'b1;
            memClear_ff             <= 1'b0;
            configStart_ff          <= 1'b0;
            fabricReset_ff          <= 1'b1;
            fabricClockEnable_ff    <= 1'b0;
            pullupEnable_ff         <= 1'b1;
        end
        else if (powerdown && supplyOk)
        begin
            // Quiet state: floated pins, no pull-ups, flops in reset
            configActiveHighFlag_ff <= configActiveHighFlag_ff;
            configActiveLowFlag_ff  <= configActiveLowFlag_ff;
            initStatusOe_ff         <= 1'b0;                  // [R12]
            doneProgramOe_ff        <= 1'b0;                  // [R12]
            pullupEnable_ff         <= 1'b0;                  // [R11]
            fabricReset_ff          <= 1'b1;                  // [R13]
            fabricClockEnable_ff    <= 1'b0;                  // [R14]
            memClear_ff             <= 1'b0;                  // [R13]
            configStart_ff          <= 1'b0;
        end
        else
        begin
            // Configuration flags active outside user mode
            configActiveHighFlag_ff <= ~inUser;               // [R01]
            configActiveLowFlag_ff  <= inUser;                // [R01]
            // Init-status driven low in pre-init and clear (slave request)
            initStatusOut_ff        <= 1'b0;
            initStatusOe_ff         <= (nxt_state == `CPS_ST_PREINIT) // [R01] [R07]
                                     || (nxt_state == `CPS_ST_CLEAR);
            // Done/program held low until startup completes
            doneProgramOut_ff       <= 1'b0;
            doneProgramOe_ff        <= (nxt_state != `CPS_ST_USER); // [R01] [R07] [R15]
            memClear_ff             <= (nxt_state == `CPS_ST_CLEAR); // [R04]
            configStart_ff          <= (state_ff == `CPS_ST_WAITRST)
                                     && (nxt_state == `CPS_ST_CONFIG);
            // Either role reconfigures on a trigger; pullups only while configuring
            pullupEnable_ff         <= (nxt_state != `CPS_ST_USER); // [R01] [R07]
            fabricReset_ff          <= (nxt_state != `CPS_ST_USER)
                                     && (nxt_state != `CPS_ST_STARTUP); // [R05]
            fabricClockEnable_ff    <= (nxt_state == `CPS_ST_USER);
        end
    end

    // Per-pin buffer control and input forcing
    genvar gi;
    generate
        for (gi = 0; gi < `CPS_NUM_PINS; gi = gi + 1)
        begin : gPin
            always @(posedge clk)
            begin
                if (!rst_n)
                    padInToLogic_ff[gi] <= 1'b1;
                else if (powerdown && supplyOk)
                    padInToLogic_ff[gi] <= 1'b1;              // [R12]
                else
                    padInToLogic_ff[gi] <= padSyncB_ff[gi];
            end
            // Three-state follows the low enable, buffers on only
            always @(posedge clk)
            begin
                if (!rst_n)
                    padThreeState_ff[gi] <= 1'b1;
                else
                    padThreeState_ff[gi] <=
                        ~(buffersOn && !powerdown) | userOutEnable_n[gi]; // [R10] [R12]
            end
        end
    endgenerate

endmodule

// ### dv/cps_seq_sva.sv
// Port assertions for the configuration power sequencer
`timescale 1ns/1ps
module cps_seq_sva
(
    input wire       clk,
    input wire       rst_n,
    input wire       supplyGood,
    input wire       powerdownRequest_n,
    input wire       configActiveHighFlag_ff,
    input wire       configActiveLowFlag_ff,
    input wire       initStatusOut_ff,
    input wire       initStatusOe_ff,
    input wire       doneProgramOut_ff,
    input wire       doneProgramOe_ff,
    input wire       memClear_ff,
    input wire       configStart_ff,
    input wire [1:0] modeLatched_ff,
    input wire       fabricReset_ff,
    input wire       fabricClockEnable_ff,
    input wire       pullupEnable_ff,
    input wire [7:0] padThreeState_ff,
    input wire [7:0] padInToLogic_ff
);
    reg [7:0] clrCnt_ff; // Cycles the clear has lasted
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Counts clear cycles so its length can be judged at the end
    always @(posedge clk)
    begin
        clrCnt_ff <= memClear_ff ? clrCnt_ff + 8'h01 : 8'h00;
    end
    a_reset_pins: assert property (@(posedge clk) disable iff (1'b0) !rst_n |=>
        configActiveHighFlag_ff && !configActiveLowFlag_ff && initStatusOe_ff
        && doneProgramOe_ff && pullupEnable_ff) else $error("reset pins wrong");
    a_pins_low: assert property (!initStatusOut_ff && !doneProgramOut_ff)
        else $error("status pin driven high");
    a_pd_quiet: assert property ((!powerdownRequest_n && supplyGood)[*5] |->
        !pullupEnable_ff && fabricReset_ff) else $error("powerdown not quiet");
    a_pd_pads: assert property ((!powerdownRequest_n && supplyGood)[*5] |->
        padThreeState_ff == 8'hFF && padInToLogic_ff == 8'hFF) else $error("pads active");
    a_pd_clock: assert property ((!powerdownRequest_n && supplyGood)[*5] |->
        !fabricClockEnable_ff) else $error("clock runs in powerdown");
    a_start_pulse: assert property (configStart_ff |=> !configStart_ff)
        else $error("start pulse too long");
    a_start_state: assert property (configStart_ff |-> !memClear_ff
        && configActiveHighFlag_ff && doneProgramOe_ff) else $error("start in wrong state");
    a_clear_len: assert property ($fell(memClear_ff) && $past(rst_n) |->
        clrCnt_ff == 8'h40) else $error("clear length wrong");
    a_brownout_pins: assert property ((!supplyGood)[*6] |-> configActiveHighFlag_ff
        && !configActiveLowFlag_ff && initStatusOe_ff && doneProgramOe_ff && pullupEnable_ff)
        else $error("low supply pins wrong");
    a_mode_latch: assert property ($changed(modeLatched_ff) && $past(rst_n) |->
        (configStart_ff || $past(configStart_ff)) or (##1 configStart_ff))
        else $error("mode latched off time");
endmodule

// ### dv/cps_sys_partner.sv
// Reset source, done/program wire and configuration source beside the sequencer
`timescale 1ns/1ps
module cps_sys_partner
(
    input  wire        clk,
    input  wire        rst_n,
    input  wire        holdReset,
    input  wire        pullProgram,
    input  wire [15:0] loadCycles,
    input  wire        configStart_ff,
    input  wire        memClear_ff,
    input  wire        doneProgramOe_ff,
    output reg         resetIn_n,
    output wire        doneProgramIn,
    output reg         configDone
);
    reg [15:0] loadCnt_ff; // Load cycles still to run
    // Open-drain line with pull-up: low when anyone pulls
    assign doneProgramIn = !(doneProgramOe_ff || pullProgram);
    // Reset driver and load timer, moved just after each edge
    always @(posedge clk)
    begin
        resetIn_n <= !holdReset;
        if (!rst_n || pullProgram || holdReset || memClear_ff)
        begin
            configDone <= 1'b0;
            loadCnt_ff <= 16'h0000;
        end
        else if (configStart_ff)
        begin
            configDone <= 1'b0;
            loadCnt_ff <= loadCycles;
        end
        else if (loadCnt_ff != 16'h0000)
        begin
            loadCnt_ff <= loadCnt_ff - 16'h0001;
            configDone <= (loadCnt_ff == 16'h0001);
        end
    end
endmodule

// ### dv/cps_config_power_sequencer_tb.sv
// Self-checking bench for the configuration power sequencer
`timescale 1ns/1ps
`include "cps_seq_map.vh"
module cps_config_power_sequencer_tb;
    reg clk = 1'b0, rst_n = 1'b0, supplyGood = 1'b0, checkCellsOk = 1'b0, isMaster = 1'b0;
    reg powerdownRequest_n = 1'b1, holdReset = 1'b0, pullProgram = 1'b0;
    reg [1:0] modePins = 2'h0;
    reg [15:0] loadCycles = 16'h0014;
    reg [7:0] padIn = 8'h00, userOutEnable_n = 8'hF0;
    wire configActiveHighFlag_ff, configActiveLowFlag_ff, initStatusOut_ff, initStatusOe_ff;
    wire doneProgramOut_ff, doneProgramOe_ff, memClear_ff, configStart_ff, fabricReset_ff;
    wire fabricClockEnable_ff, pullupEnable_ff, resetIn_n, doneProgramIn, configDone;
    wire [1:0] modeLatched_ff;
    wire [7:0] padThreeState_ff, padInToLogic_ff;
    integer mismatches = 0, checks_done = 0, n;
    cps_config_power_sequencer dut (.*);
    cps_sys_partner peer (.*);
    // 40 MHz clock
    initial forever #12.5 clk = ~clk;
    task tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task chk(input [31:0] exp, input [31:0] got, input [8*12-1:0] nm);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("BAD %0s expected %0h seen %0h", nm, exp, got);
        end
    end
    endtask
    // Condition codes: 0 clear on, 1 start pulse, 2 released, 3 program held low
    function hit(input [1:0] sel);
        hit = sel == 2'h0 ? memClear_ff === 1'b1 : sel == 2'h1 ? configStart_ff === 1'b1
            : doneProgramOe_ff === sel[0];
    endfunction
    task waitFor(input [1:0] sel, input integer lim, input must);
    begin
        n = 0;
        while (!hit(sel) && n < lim)
        begin
            @(negedge clk);
            n = n + 1;
        end
        if (must && n >= lim)
        begin
            mismatches = mismatches + 1;
            $display("BAD wait %0d expected hit seen timeout", sel);
            tally_and_finish;
        end
    end
    endtask
    task t_powerup(input m);
    begin
        @(posedge clk);
        {isMaster, holdReset, supplyGood, modePins} <= {m, 1'b1, 1'b1, m, 1'b1};
        repeat (100) @(posedge clk);
        checkCellsOk <= 1'b1;
        waitFor(2'h0, 9000, 1'b1);
        n = n - (m ? `CPS_INIT_DELAY_SLAVE * `CPS_MASTER_FACTOR : `CPS_INIT_DELAY_SLAVE);
        chk(1, n >= 0 && n <= 8, "initDelay");
        waitFor(2'h1, 100, 1'b0);
        chk(100, n, "startHeld");
        @(posedge clk) holdReset <= 1'b0;
        waitFor(2'h1, 10, 1'b1);
        @(negedge clk) chk({m, 1'b1}, modeLatched_ff, "mode");
        waitFor(2'h2, 60, 1'b1);
        chk(2'h1, {configActiveHighFlag_ff, configActiveLowFlag_ff}, "flags");
        $display("power-up test done");
    end
    endtask
    task t_brownout;
    begin
        @(posedge clk) {supplyGood, checkCellsOk} <= 2'h0;
        repeat (20) @(negedge clk);
        chk(5'h17, {configActiveHighFlag_ff, configActiveLowFlag_ff, initStatusOe_ff,
            doneProgramOe_ff, pullupEnable_ff}, "lowSupply");
        $display("brown-out test done");
    end
    endtask
    task t_retrigger;
    begin
        @(posedge clk) {pullProgram, loadCycles} <= {1'b1, 16'h0BB8};
        repeat (4) @(posedge clk);
        pullProgram <= 1'b0;
        waitFor(2'h3, 10, 1'b1);
        chk(2'h2, {configActiveHighFlag_ff, configActiveLowFlag_ff}, "progFlags");
        waitFor(2'h1, 11000, 1'b1);
        @(posedge clk) holdReset <= 1'b1;
        repeat (4) @(posedge clk);
        {holdReset, loadCycles} <= {1'b0, 16'h0014};
        waitFor(2'h1, 11000, 1'b1);
        waitFor(2'h2, 200, 1'b1);
        chk(2'h1, {configActiveHighFlag_ff, configActiveLowFlag_ff}, "rstFlags");
        $display("retrigger test done");
    end
    endtask
    task t_powerdown;
    begin
        @(posedge clk) powerdownRequest_n <= 1'b0;
        repeat (10) @(negedge clk);
        chk(8'hFF, padInToLogic_ff, "pdInputs");
        chk(8'hFF, padThreeState_ff, "pdOutputs");
        chk(3'h2, {pullupEnable_ff, fabricReset_ff, fabricClockEnable_ff}, "pdCore");
        @(posedge clk) {powerdownRequest_n, padIn} <= {1'b1, 8'h5A};
        repeat (12) @(negedge clk);
        chk(3'h1, {doneProgramOe_ff, fabricReset_ff, fabricClockEnable_ff}, "pdResume");
        chk(8'h5A, padInToLogic_ff, "pdPads");
        chk(8'hF0, padThreeState_ff, "userPads");
        $display("powerdown test done");
    end
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk(5'h17, {configActiveHighFlag_ff, configActiveLowFlag_ff, initStatusOe_ff,
            doneProgramOe_ff, pullupEnable_ff}, "preInit");
        t_powerup(1'b0);
        t_powerdown;
        t_retrigger;
        t_brownout;
        t_powerup(1'b1);
        tally_and_finish;
    end
endmodule
bind cps_config_power_sequencer cps_seq_sva sva (.*);
